// >>> core/sarpc_pkg.sv
// constants for the sar converter parallel control block
package sarpc_pkg;
  localparam int          CLK_MHZ        = 20;
  localparam int          CONV_TIME_NS   = 200;
  // longest time rounds down
  localparam int          CONV_CYCLES    = (CONV_TIME_NS * CLK_MHZ) / 1000;
  localparam int          CNT_W          = 4;
  localparam int          DATA_W         = 12;
  localparam logic [11:0] ABORT_CODE     = 12'hFE0;
  localparam logic [11:0] RESET_CODE     = 12'hFE0;
  localparam logic [11:0] DATA_RESET     = 12'h000;
  localparam int          INIT_CONVS     = 4;
  localparam int          BYTE_HI_W      = 4;
  typedef enum logic [1:0] {SARPC_IDLE, SARPC_SAMPLE, SARPC_CONVERT} sarpc_state_t;
endpackage

// >>> core/sarpc_sync_if.sv
// synchronised host control levels passed to the control logic; only chip select and start feed its edge detector
`timescale 1ns/1ps
interface sarpc_sync_if;
  logic csN;
  logic convStartN;
  logic readN;
  logic byteSel;
  logic nap;
  logic pdN;
  modport src (output csN, output convStartN, output readN, output byteSel, output nap, output pdN);
  modport dst (input csN, input convStartN, input readN, input byteSel, input nap, input pdN);
endinterface

// >>> core/sarpc_sync.sv
// two-flop synchronisers for all asynchronous host pins
`timescale 1ns/1ps
module sarpc_sync
(
  input  wire logic   mclk,
  input  wire logic   rst,
  input  wire logic   csNIn,
  input  wire logic   convStartNIn,
  input  wire logic   readNIn,
  input  wire logic   byteSelIn,
  input  wire logic   napEnableNIn,
  input  wire logic   pdNIn,
  sarpc_sync_if.src   syncOut
);
  logic [5:0] stage1_reg;
  logic [5:0] stage2_reg;

  // idle levels: chip select and read high, start and byte select low, reset released
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      stage1_reg <= 6'h35;
      stage2_reg <= 6'h35;
    end
    else
    begin
      stage1_reg <= {pdNIn, napEnableNIn, byteSelIn, readNIn, convStartNIn, csNIn};
      stage2_reg <= stage1_reg;
    end
  end

  assign syncOut.csN        = stage2_reg[0];
  assign syncOut.convStartN = stage2_reg[1];
  assign syncOut.readN      = stage2_reg[2];
  assign syncOut.byteSel    = stage2_reg[3];
  assign syncOut.nap        = ~stage2_reg[4];
  assign syncOut.pdN        = stage2_reg[5];
endmodule

// >>> core/sar_adc_ctrl.sv
// control and parallel readout of a 12-bit successive-approximation converter
//
// Summary of operation
// R1 - A rising conversion-start edge starts sampling when chip select and busy are low.
// R2 - A falling chip-select edge starts sampling when conversion-start is high and busy is low.
// R3 - With chip select low and conversion-start high, sampling restarts at internal conversion end.
// R4 - A falling conversion-start edge with chip select low ends sampling and starts a conversion.
// R5 - A falling chip-select edge with conversion-start low ends sampling and starts a conversion.
// R6 - Busy rises right after the starting edge, stays high through conversion, then falls.
// R7 - Each conversion finishes within the maximum conversion time, busy following after a short delay.
// R8 - A falling chip-select edge while busy and conversion-start are high aborts and yields FE0 hex.
// R9 - The bus is driven only while chip select and read are both low, otherwise released.
// R10 - With byte select low a read shows all twelve bits, bit 11 on the top line.
// R11 - With byte select high a read shows bits 3..0 in the top lines and zeros below.
// R12 - The host uses back-to-back operation for throughput above 2.83 MSPS.
// R13 - The host avoids the abort condition in back-to-back operation.
// R14 - The host may restart acquisition early if its start pulse is long enough.
// R15 - During reset the output code is FE0 hex and the first four conversions are flagged invalid.
// R16 - With nap enabled the device naps after busy falls until sampling starts.
// R17 - Each completed result is held and read back until the next completion or abort.
`timescale 1ns/1ps
module sar_adc_ctrl
(
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        csN,
  input  wire logic        convStartN,
  input  wire logic        readN,
  input  wire logic        byteSel,
  input  wire logic        napEnableN,
  input  wire logic        powerdownResetN,
  input  wire logic [11:0] sampleCode,
  output logic             busy,
  output logic [11:0]      dataOut,
  output logic [11:0]      dataOe,
  output logic             sampling,
  output logic             napping,
  output logic             dataInvalid
);
  sarpc_sync_if sync ();

  sarpc_sync u_sync
  (
    .mclk         (mclk),
    .rst          (rst),
    .csNIn        (csN),
    .convStartNIn (convStartN),
    .readNIn      (readN),
    .byteSelIn    (byteSel),
    .napEnableNIn (napEnableN),
    .pdNIn        (powerdownResetN),
    .syncOut      (sync.src)
  );

  sarpc_pkg::sarpc_state_t state_reg;
  logic                     csPrev_reg;
  logic                     startPrev_reg;
  logic [sarpc_pkg::CNT_W-1:0] convCnt_reg;
  logic [11:0]              result_reg;
  logic [11:0]              capture_reg;
  logic [2:0]               initCnt_reg;
  logic                     inReset;
  logic                     csFall;
  logic                     startRise;
  logic                     startFall;
  logic                     convEnd;
  logic                     abortHit;
  logic                     convBegin;
  logic                     sampleBegin;
  logic [11:0]              busValue;

  assign inReset   = ~sync.pdN;
  assign csFall    = csPrev_reg & ~sync.csN;
  assign startRise = ~startPrev_reg & sync.convStartN;
  assign startFall = startPrev_reg & ~sync.convStartN;
  // host pin level high means pin high; convStartN pin high means start input high
  assign convEnd   = (state_reg == sarpc_pkg::SARPC_CONVERT) &&
                     (convCnt_reg == sarpc_pkg::CNT_W'(sarpc_pkg::CONV_CYCLES - 1)); // see R7
  assign abortHit  = busy && csFall && sync.convStartN;                       // see R8
  assign convBegin = (state_reg == sarpc_pkg::SARPC_SAMPLE) &&
                     ((startFall && ~sync.csN) || (csFall && ~sync.convStartN)); // see R4, R5
  assign sampleBegin = (state_reg == sarpc_pkg::SARPC_IDLE) && ~busy &&
                       ((startRise && ~sync.csN) || (csFall && sync.convStartN)); // see R1, R2

  // edge history of the synchronised pins
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      csPrev_reg    <= 1'b1;
      startPrev_reg <= 1'b0;
    end
    else
    begin
      csPrev_reg    <= sync.csN;
      startPrev_reg <= sync.convStartN;
    end
  end

  // sequencing: idle (nap when enabled), sampling, converting
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      state_reg   <= sarpc_pkg::SARPC_IDLE;
      convCnt_reg <= '0;
    end
    else if (inReset || abortHit)
    begin
      state_reg   <= sarpc_pkg::SARPC_IDLE;                                   // see R8
      convCnt_reg <= '0;
    end
    else
    begin
      case (state_reg)
        sarpc_pkg::SARPC_IDLE:
        begin
          if (sampleBegin)
            state_reg <= sarpc_pkg::SARPC_SAMPLE;
        end
        sarpc_pkg::SARPC_SAMPLE:
        begin
          convCnt_reg <= '0;
          if (convBegin)
            state_reg <= sarpc_pkg::SARPC_CONVERT;
        end
        sarpc_pkg::SARPC_CONVERT:
        begin
          convCnt_reg <= convCnt_reg + 1'b1;
          if (convEnd)
          begin
            // back-to-back: start held high with select low restarts sampling at once
            if (~sync.csN && sync.convStartN)
              state_reg <= sarpc_pkg::SARPC_SAMPLE;                           // see R3
            else
              state_reg <= sarpc_pkg::SARPC_IDLE;
          end
        end
        default:
        begin
          state_reg <= sarpc_pkg::SARPC_IDLE;
        end
      endcase
    end
  end

  // busy rises the cycle after the starting edge and falls one cycle after conversion end
  always_ff @(posedge mclk)
  begin
    if (rst)
      busy <= 1'b0;
    else if (inReset || abortHit)
      busy <= 1'b0;
    else if (convBegin)
      busy <= 1'b1;                                                           // see R6
    else if (convEnd)
      busy <= 1'b0;                                                           // see R6
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      sampling <= 1'b0;
      napping  <= 1'b0;
    end
    else
    begin
      sampling <= (state_reg == sarpc_pkg::SARPC_SAMPLE);
      // outside reset and with nap enabled, nap ends only when sampling begins, so the first acquisition pays the wake-up time
      napping  <= sync.nap && ~inReset && (state_reg == sarpc_pkg::SARPC_IDLE) && ~busy && ~sampleBegin; // see R16
    end
  end

  // the analog value is frozen at the end of sampling
  always_ff @(posedge mclk)
  begin
    if (rst)
      capture_reg <= sarpc_pkg::DATA_RESET;
    else if (convBegin)
      capture_reg <= sampleCode;
  end

  // held result
  always_ff @(posedge mclk)
  begin
    if (rst)
      result_reg <= sarpc_pkg::RESET_CODE;
    else if (inReset)
      result_reg <= sarpc_pkg::RESET_CODE;                                    // see R15
    else if (abortHit)
      result_reg <= sarpc_pkg::ABORT_CODE;                                    // see R8
    else if (convEnd)
      result_reg <= capture_reg;                                              // see R17
  end

  // initialisation count of conversions after reset
  always_ff @(posedge mclk)
  begin
    if (rst)
      initCnt_reg <= '0;
    else if (inReset)
      initCnt_reg <= '0;
    else if (convEnd && initCnt_reg != 3'(sarpc_pkg::INIT_CONVS))
      initCnt_reg <= initCnt_reg + 1'b1;                                      // see R15
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
      dataInvalid <= 1'b1;
    else
      dataInvalid <= (initCnt_reg != 3'(sarpc_pkg::INIT_CONVS));              // see R15
  end

  always_comb
  begin
    if (sync.byteSel)
      busValue = {result_reg[sarpc_pkg::BYTE_HI_W-1:0], 8'h00};              // see R11
    else
      busValue = result_reg;                                                  // see R10
  end

  // bus drive; a read during the abort cycle shows the old word for one cycle
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      dataOut <= 12'h000;
      dataOe  <= 12'h000;
    end
    else
    begin
      dataOut <= busValue;
      dataOe  <= (~sync.csN && ~sync.readN) ? 12'hFFF : 12'h000;              // see R9
    end
  end
endmodule

// >>> bench/sarpc_chk_sva.sv
// pin-level assertions for the converter control block
`timescale 1ns/1ps
module sarpc_chk
(
  input wire logic        mclk,
  input wire logic        rst,
  input wire logic        csN,
  input wire logic        readN,
  input wire logic        byteSel,
  input wire logic        napEnableN,
  input wire logic        powerdownResetN,
  input wire logic        busy,
  input wire logic [11:0] dataOut,
  input wire logic [11:0] dataOe,
  input wire logic        sampling,
  input wire logic        napping
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  property p_busy_len; $rose(busy) |-> ##4 !busy; endproperty
  a_busy_len: assert property (p_busy_len) else $error("busy too long");
  property p_from_smp; $rose(busy) |-> $past(sampling, 2); endproperty
  a_from_smp: assert property (p_from_smp) else $error("busy without sampling");
  // five cycles covers the pin synchronisers plus the output register
  property p_oe_off; (csN || readN)[*5] |-> dataOe == 12'h000; endproperty
  a_oe_off: assert property (p_oe_off) else $error("bus not released");
  property p_oe_on; (!csN && !readN)[*5] |-> dataOe == 12'hFFF; endproperty
  a_oe_on: assert property (p_oe_on) else $error("bus not driven");
  property p_fold; (byteSel && !csN && !readN)[*5] |-> dataOut[7:0] == 8'h00; endproperty
  a_fold: assert property (p_fold) else $error("fold low bits");
  property p_nap_busy; napping |-> !busy; endproperty
  a_nap_busy: assert property (p_nap_busy) else $error("nap in conversion");
  property p_nap_off; napEnableN[*6] |-> !napping; endproperty
  a_nap_off: assert property (p_nap_off) else $error("nap not enabled");
  property p_pd_code; (!powerdownResetN && !csN && !readN && !byteSel)[*6] |-> dataOut == 12'hFE0; endproperty
  a_pd_code: assert property (p_pd_code) else $error("reset code");
endmodule
bind sar_adc_ctrl sarpc_chk chk (.*);

// >>> bench/sarpc_host.sv
// host model driving the converter's control and read pins
`timescale 1ns/1ps
module sarpc_host
(
  input  wire logic        mclk,
  input  wire logic        busy,
  input  wire logic [11:0] dataOut,
  input  wire logic [11:0] dataOe,
  output logic             csN,
  output logic             convStartN,
  output logic             readN,
  output logic             byteSel
);
  initial {csN, convStartN, readN, byteSel} = 4'hA;
  // levels are held n cycles so every edge clears the synchronisers
  task automatic pins(input logic c, input logic s, input int n);
    @(negedge mclk);
    csN = c;
    convStartN = s;
    repeat (n) @(negedge mclk);
  endtask
  // chip select held low and timing set by the start pin, so the abort pattern never arises here
  task automatic conv(output logic [11:0] hi);
    hi = 12'h000;
    pins(1'b0, 1'b1, 4);
    pins(1'b0, 1'b0, 0);
    repeat (12)
    begin
      @(negedge mclk);
      if (busy === 1'b1)
        hi = hi + 12'h001;
    end
  endtask
  task automatic rd(input logic bs, output logic [11:0] d, output logic [11:0] oe);
    @(negedge mclk);
    byteSel = bs;
    readN = 1'b0;
    repeat (6) @(negedge mclk);
    d = dataOut;
    oe = dataOe;
    readN = 1'b1;
  endtask
endmodule

// >>> bench/testbench.sv
// self-checking bench for the converter control block
`timescale 1ns/1ps
module testbench;
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic        napEnableN = 1'b1;
  logic        powerdownResetN = 1'b1;
  logic [11:0] sampleCode = 12'h000;
  logic        csN, convStartN, readN, byteSel, busy, sampling, napping, dataInvalid;
  logic [11:0] dataOut, dataOe, d, oe, hi;
  int          miscompares = 0;
  int          checks = 0;
  int          cyc = 0;
  initial forever #25 mclk = ~mclk;
  sar_adc_ctrl dut (.*);
  sarpc_host host (.*);
  task automatic chk(input logic [11:0] g, input logic [11:0] e);
    checks++;
    if (g !== e)
    begin
      miscompares++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic test_done;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      miscompares++;
      test_done;
    end
  end
  task automatic t_basic;
    for (int i = 0; i < 4; i++)
    begin
      chk(12'(dataInvalid), 12'h001);
      sampleCode = 12'hABC;
      host.conv(hi);
    end
    chk(12'(dataInvalid), 12'h000);
    chk(hi, 12'h004);
    host.rd(1'b0, d, oe);
    chk(d, 12'hABC);
    chk(oe, 12'hFFF);
    host.rd(1'b1, d, oe);
    chk(d, 12'hC00);
    host.pins(1'b1, 1'b0, 3);
    host.rd(1'b0, d, oe);
    chk(oe, 12'h000);
    $display("basic end");
  endtask
  task automatic t_cs;
    sampleCode = 12'h5A5;
    host.pins(1'b1, 1'b1, 4);
    chk(12'(sampling), 12'h000);
    host.pins(1'b0, 1'b1, 6);
    chk(12'(sampling), 12'h001);
    host.pins(1'b1, 1'b1, 4);
    host.pins(1'b1, 1'b0, 4);
    host.pins(1'b0, 1'b0, 12);
    sampleCode = 12'h000;
    host.rd(1'b0, d, oe);
    chk(d, 12'h5A5);
    $display("cs end");
  endtask
  task automatic t_b2b;
    sampleCode = 12'h111;
    host.pins(1'b0, 1'b1, 6);
    host.pins(1'b0, 1'b0, 3);
    host.pins(1'b0, 1'b1, 8);
    sampleCode = 12'h222;
    chk(12'(sampling), 12'h001);
    host.pins(1'b0, 1'b0, 12);
    host.rd(1'b0, d, oe);
    chk(d, 12'h222);
    $display("b2b end");
  endtask
  task automatic t_abort;
    host.pins(1'b0, 1'b1, 6);
    host.pins(1'b1, 1'b1, 4);
    host.pins(1'b1, 1'b0, 4);
    host.pins(1'b0, 1'b0, 0);
    host.pins(1'b0, 1'b1, 0);
    host.pins(1'b1, 1'b1, 0);
    host.pins(1'b0, 1'b1, 10);
    host.rd(1'b0, d, oe);
    chk(d, 12'hFE0);
    $display("abort end");
  endtask
  task automatic t_nap;
    napEnableN = 1'b0;
    host.pins(1'b0, 1'b0, 12);
    chk(12'(napping), 12'h001);
    host.pins(1'b0, 1'b1, 6);
    chk(12'(napping), 12'h000);
    napEnableN = 1'b1;
    host.pins(1'b0, 1'b0, 12);
    $display("nap end");
  endtask
  task automatic t_pd;
    powerdownResetN = 1'b0;
    host.rd(1'b0, d, oe);
    chk(d, 12'hFE0);
    chk(12'(dataInvalid), 12'h001);
    powerdownResetN = 1'b1;
    host.conv(hi);
    chk(12'(dataInvalid), 12'h001);
    $display("pd end");
  endtask
  initial
  begin
    repeat (6) @(negedge mclk);
    rst = 1'b0;
    t_basic;
    t_cs;
    t_b2b;
    t_abort;
    t_nap;
    t_pd;
    test_done;
  end
endmodule
